// ==== hdl/dpmsc_top.sv ====
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module dpmsc_top #(
  parameter int FRAME_CYC   = dpmsc_pkg::FRAME_CYC,
  parameter int LOCK_FRAMES = dpmsc_pkg::LOCK_FRAMES,
  parameter int FAST_FRAMES = dpmsc_pkg::FAST_FRAMES,
  parameter int MON_FRAMES  = dpmsc_pkg::MON_FRAMES,
  parameter int LOSS_CYC    = dpmsc_pkg::LOSS_CYC,
  parameter int FW          = dpmsc_pkg::FREQ_W,
  parameter logic [FW-1:0] NOMINAL_WORD = '0
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [3:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [3:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          op_select_hi,
  input  wire logic          op_select_lo,
  input  wire logic          ref_select,
  input  wire logic          phase_step_correct_enable,
  input  wire logic          quick_acquire_enable,
  input  wire logic          ref0_freq_code_hi,
  input  wire logic          ref0_freq_code_lo,
  input  wire logic          ref1_freq_code_hi,
  input  wire logic          ref1_freq_code_lo,
  input  wire logic          reference_in_a,
  input  wire logic          reference_in_b,
  input  wire logic [FW-1:0] dco_freq_word,
  output logic               frame_sync_8k_out,
  output logic               normal_ind,
  output logic               holdover_ind,
  output logic               freerun_ind,
  output logic               lock_ind,
  output logic               quick_acquire_active,
  output logic               phase_step_correct_active,
  output logic               ref_a_ppm_alarm,
  output logic               ref_b_ppm_alarm,
  output logic [FW-1:0]      dco_freq_target
);
  localparam int FC_W = $clog2(FRAME_CYC + 1);
  localparam int LK_W = $clog2(LOCK_FRAMES + FAST_FRAMES + 1);
  localparam int MN_W = $clog2(MON_FRAMES + 1);
  localparam int LS_W = $clog2(LOSS_CYC + 1);
  localparam int SF_W = $clog2(dpmsc_pkg::STORE_FRAMES + 1);
  localparam int EW   = dpmsc_pkg::EDGE_W;
  localparam logic [EW-1:0] EXP [4] = '{
    EW'(dpmsc_pkg::PF_19M44 * MON_FRAMES),
    EW'(dpmsc_pkg::PF_8K * MON_FRAMES),
    EW'(dpmsc_pkg::PF_1M544 * MON_FRAMES),
    EW'(dpmsc_pkg::PF_2M048 * MON_FRAMES)
  };

  // Pin synchronisers
  logic [10:0] pin_meta;
  logic [10:0] pin_sync;
  always_ff @(posedge aclk) begin
    pin_meta <= {op_select_hi, op_select_lo, ref_select, phase_step_correct_enable,
                 quick_acquire_enable, ref0_freq_code_hi, ref0_freq_code_lo,
                 ref1_freq_code_hi, ref1_freq_code_lo, reference_in_a, reference_in_b};
    pin_sync <= pin_meta;
  end

  logic [1:0] op_code;
  logic       sel_pin;
  logic       tie_pin;
  logic       quick_pin;
  logic [1:0] ref_lvl;
  assign op_code   = pin_sync[10:9];
  assign sel_pin   = pin_sync[8];
  assign tie_pin   = pin_sync[7];
  assign quick_pin = pin_sync[6];
  assign ref_lvl   = pin_sync[1:0];

  // Frequency codes held from reset
  logic [1:0] code_a;
  logic [1:0] code_b;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_a <= pin_sync[5:4];
      code_b <= pin_sync[3:2];
    end
  end

  // Frame timing
  logic [FC_W-1:0] frame_cnt;
  logic            tick;
  assign tick = (frame_cnt == '0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_cnt         <= '0;
      frame_sync_8k_out <= 1'b0;
    end else begin
      frame_cnt <= (frame_cnt == FC_W'(FRAME_CYC - 1)) ? '0 : frame_cnt + 1'b1;
      frame_sync_8k_out <= (frame_cnt < FC_W'(dpmsc_pkg::FSYNC_CYC));
    end
  end

  // Bus control and state
  logic [1:0]                ctrl;
  dpmsc_pkg::dpmsc_state_t   state;
  dpmsc_pkg::dpmsc_state_t   next_state;
  logic                      active_sel;
  logic                      invalid;
  logic                      trans_flag;
  logic                      tie_on;
  logic                      ref_gate;
  assign ref_gate = (state != dpmsc_pkg::ST_FREE) && (state != dpmsc_pkg::ST_HOLD);

  // Reference edge selection
  logic [1:0] ref_prev;
  logic [1:0] ref_edge;
  logic       sel_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_prev <= 2'h0;
    end else begin
      ref_prev <= ref_lvl;
    end
  end
  assign ref_edge[1] = (code_a == dpmsc_pkg::CODE_19M44) ? (ref_lvl[1] & ~ref_prev[1])
                                                          : (~ref_lvl[1] & ref_prev[1]);
  assign ref_edge[0] = (code_b == dpmsc_pkg::CODE_19M44) ? (ref_lvl[0] & ~ref_prev[0])
                                                          : (~ref_lvl[0] & ref_prev[0]);
  assign sel_edge = ref_gate & (active_sel ? ref_edge[0] : ref_edge[1]);

  // Loss of selected reference
  logic [LS_W-1:0] loss_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || sel_edge || !ref_gate) begin
      loss_cnt <= '0;
    end else if (loss_cnt != LS_W'(LOSS_CYC)) begin
      loss_cnt <= loss_cnt + 1'b1;
    end
  end
  assign invalid = (loss_cnt == LS_W'(LOSS_CYC)) | ctrl[1];

  // Select transient, held until the next frame
  logic sel_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_prev   <= sel_pin;
      trans_flag <= 1'b0;
    end else begin
      sel_prev <= sel_pin;
      if (sel_pin != sel_prev) begin
        trans_flag <= 1'b1;
      end else if (tick) begin
        trans_flag <= 1'b0;
      end
    end
  end

  // Mode decision
  always_comb begin
    next_state = state;
    if (op_code == dpmsc_pkg::OP_FREE) begin
      next_state = dpmsc_pkg::ST_FREE;
    end else if (op_code == dpmsc_pkg::OP_HOLD) begin
      next_state = dpmsc_pkg::ST_HOLD;
    end else if (op_code == dpmsc_pkg::OP_NORMAL) begin
      unique case (state)
        dpmsc_pkg::ST_FREE, dpmsc_pkg::ST_HOLD: begin
          next_state = dpmsc_pkg::ST_NORM;
        end
        dpmsc_pkg::ST_NORM: begin
          if (trans_flag) begin
            next_state = dpmsc_pkg::ST_SHORT;
          end else if (invalid) begin
            next_state = dpmsc_pkg::ST_AUTO;
          end
        end
        dpmsc_pkg::ST_AUTO: begin
          if (trans_flag) begin
            next_state = dpmsc_pkg::ST_SHORT;
          end else if (!invalid) begin
            next_state = dpmsc_pkg::ST_NORM;
          end
        end
        dpmsc_pkg::ST_SHORT: begin
          if (!trans_flag) begin
            next_state = dpmsc_pkg::ST_NORM;
          end
        end
        default: begin
          next_state = dpmsc_pkg::ST_FREE;
        end
      endcase
    end
    // Reserved code leaves next_state as is
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= dpmsc_pkg::ST_FREE;
    end else if (tick) begin
      state <= next_state;
    end
  end

  // Active reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_sel <= sel_pin;
    end else if (tick && next_state == dpmsc_pkg::ST_NORM &&
                 state != dpmsc_pkg::ST_NORM && state != dpmsc_pkg::ST_AUTO) begin
      active_sel <= sel_pin;
    end
  end

  // Phase-step correction enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tie_on <= 1'b0;
    end else if (tick && next_state != state) begin
      if (next_state == dpmsc_pkg::ST_NORM && state != dpmsc_pkg::ST_FREE) begin
        tie_on <= tie_pin;
      end else begin
        tie_on <= 1'b0;
      end
    end
  end
  assign phase_step_correct_active = tie_on & ~ctrl[0];

  // Status indicators
  assign normal_ind   = state[1];
  assign holdover_ind = state[2] | state[3] | state[4];
  assign freerun_ind  = state[0];
  assign quick_acquire_active = state[1] & quick_pin;

  // Lock timer
  logic [LK_W-1:0] lock_cnt;
  logic [LK_W-1:0] lock_lim;
  assign lock_lim = quick_pin ? LK_W'(FAST_FRAMES - 1) : LK_W'(LOCK_FRAMES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn || state != dpmsc_pkg::ST_NORM) begin
      lock_cnt <= '0;
      lock_ind <= 1'b0;
    end else if (tick && !lock_ind) begin
      lock_cnt <= lock_cnt + 1'b1;
      lock_ind <= (lock_cnt >= lock_lim);
    end
  end

  // Holdover frequency storage
  logic [FW-1:0]   slot [2];
  logic            wr_ptr;
  logic [SF_W-1:0] store_cnt;
  logic [FW-1:0]   hold_freq;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot[0]   <= NOMINAL_WORD;
      slot[1]   <= NOMINAL_WORD;
      wr_ptr    <= 1'b0;
      store_cnt <= '0;
    end else if (lock_ind && tick) begin
      if (store_cnt == SF_W'(dpmsc_pkg::STORE_FRAMES - 1)) begin
        store_cnt    <= '0;
        slot[wr_ptr] <= dco_freq_word;
        wr_ptr       <= ~wr_ptr;
      end else begin
        store_cnt <= store_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_freq <= NOMINAL_WORD;
    end else if (tick && next_state != state &&
                 (state == dpmsc_pkg::ST_NORM || state == dpmsc_pkg::ST_FREE) &&
                 next_state != dpmsc_pkg::ST_NORM && next_state != dpmsc_pkg::ST_FREE) begin
      hold_freq <= slot[wr_ptr];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dco_freq_target <= NOMINAL_WORD;
    end else if (state == dpmsc_pkg::ST_NORM) begin
      dco_freq_target <= dco_freq_word;
    end else if (state == dpmsc_pkg::ST_FREE) begin
      dco_freq_target <= NOMINAL_WORD;
    end else begin
      dco_freq_target <= hold_freq;
    end
  end

  // Reference ppm monitors
  logic [MN_W-1:0] mon_cnt;
  logic            gate_end;
  logic [1:0]      alarm;
  assign gate_end = tick && (mon_cnt == MN_W'(MON_FRAMES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || gate_end) begin
      mon_cnt <= '0;
    end else if (tick) begin
      mon_cnt <= mon_cnt + 1'b1;
    end
  end

  generate
    for (genvar i = 0; i < 2; i++) begin : g_mon
      logic [EW-1:0] cnt;
      logic [EW-1:0] exp_cnt;
      logic [EW-1:0] dev;
      logic          flag;
      assign exp_cnt = EXP[(i == 0) ? code_a : code_b];
      assign dev = (cnt > exp_cnt) ? cnt - exp_cnt : exp_cnt - cnt;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt  <= '0;
          flag <= 1'b0;
        end else if (gate_end) begin
          cnt  <= '0;
          flag <= (dev > dpmsc_pkg::dpmsc_tol(exp_cnt));
        end else if (ref_edge[1-i]) begin
          cnt <= cnt + 1'b1;
        end
      end
      assign alarm[i] = flag;
    end
  endgenerate
  assign ref_a_ppm_alarm = alarm[0];
  assign ref_b_ppm_alarm = alarm[1];

  // AXI4-Lite write path
  logic wr_go;
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dpmsc_pkg::RESP_OKAY;
      ctrl         <= dpmsc_pkg::CTRL_RST;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= dpmsc_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        dpmsc_pkg::ADDR_CTRL: begin
          if (s_axi_wstrb[0]) begin
            ctrl <= s_axi_wdata[1:0];
          end
        end
        dpmsc_pkg::ADDR_STATUS, dpmsc_pkg::ADDR_HOLD, dpmsc_pkg::ADDR_CODES: begin
        end
        default: begin
          s_axi_bresp <= dpmsc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read path
  logic rd_go;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= dpmsc_pkg::RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= dpmsc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dpmsc_pkg::ADDR_CTRL: s_axi_rdata <= {30'h0, ctrl};
        dpmsc_pkg::ADDR_STATUS: begin
          s_axi_rdata <= {21'h0, invalid, active_sel, alarm, phase_step_correct_active,
                          lock_ind, state};
        end
        dpmsc_pkg::ADDR_HOLD: s_axi_rdata <= 32'(hold_freq);
        dpmsc_pkg::ADDR_CODES: s_axi_rdata <= {28'h0, code_b, code_a};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= dpmsc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/dpmsc_pkg.sv ====
package dpmsc_pkg;
  localparam int CLK_NS       = 10;
  localparam int FRAME_NS     = 125000;
  localparam int FRAME_CYC    = FRAME_NS / CLK_NS;
  localparam int FSYNC_NS     = 122;
  localparam int FSYNC_CYC    = (FSYNC_NS / CLK_NS < 1) ? 1 : FSYNC_NS / CLK_NS;
  localparam int FRAMES_PER_MS = 1000000 / FRAME_NS;
  localparam int LOCK_MS      = 30000;
  localparam int FAST_LOCK_MS = 500;
  localparam int STORE_MS     = 30;
  localparam int MON_MS       = 2000;
  localparam int LOCK_FRAMES  = LOCK_MS * FRAMES_PER_MS;
  localparam int FAST_FRAMES  = FAST_LOCK_MS * FRAMES_PER_MS;
  localparam int STORE_FRAMES = STORE_MS * FRAMES_PER_MS;
  localparam int MON_FRAMES   = MON_MS * FRAMES_PER_MS;
  localparam int LOSS_CYC     = 2 * FRAME_CYC;
  localparam int PPM_LIMIT    = 12;
  localparam int FREQ_W       = 24;
  localparam int EDGE_W       = 27;
  // Reference edges per frame for each frequency code
  localparam int PF_19M44     = 2430;
  localparam int PF_8K        = 1;
  localparam int PF_1M544     = 193;
  localparam int PF_2M048     = 256;
  localparam logic [1:0] OP_NORMAL  = 2'h0;
  localparam logic [1:0] OP_HOLD    = 2'h1;
  localparam logic [1:0] OP_FREE    = 2'h2;
  localparam logic [1:0] CODE_19M44 = 2'h0;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_HOLD   = 4'h8;
  localparam logic [3:0] ADDR_CODES  = 4'hc;
  localparam logic [1:0] CTRL_RST    = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    ST_FREE  = 5'h01,
    ST_NORM  = 5'h02,
    ST_AUTO  = 5'h04,
    ST_HOLD  = 5'h08,
    ST_SHORT = 5'h10
  } dpmsc_state_t;
  function automatic logic [EDGE_W-1:0] dpmsc_tol(input logic [EDGE_W-1:0] e);
    return EDGE_W'((64'(e) * 64'(PPM_LIMIT)) / 64'd1000000);
  endfunction
endpackage

// ==== test/dpmsc_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpmsc_asserts #(
  parameter int FRAME_CYC   = 50,
  parameter int LOCK_FRAMES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_sync_8k_out,
  input wire logic normal_ind,
  input wire logic holdover_ind,
  input wire logic freerun_ind,
  input wire logic lock_ind,
  input wire logic quick_acquire_enable,
  input wire logic quick_acquire_active,
  input wire logic phase_step_correct_enable,
  input wire logic phase_step_correct_active
);
  localparam int LK = FRAME_CYC * (LOCK_FRAMES + 2);
  int   gap;
  int   ncnt;
  logic seen;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Cycles since the last frame pulse start
  always_ff @(posedge aclk) begin
    if (!aresetn || $rose(frame_sync_8k_out)) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 1'b0;
    end else if ($rose(frame_sync_8k_out)) begin
      seen <= 1'b1;
    end
  end
  // Unbroken cycles in normal
  always_ff @(posedge aclk) begin
    if (!aresetn || !normal_ind) begin
      ncnt <= 0;
    end else if (ncnt <= LK) begin
      ncnt <= ncnt + 1;
    end
  end
  a_one_mode: assert property ($onehot({normal_ind, holdover_ind, freerun_ind}))
    else $error("mode indicators not one-hot");
  a_tick_only: assert property (!$stable({normal_ind, holdover_ind, freerun_ind}) |->
    (frame_sync_8k_out && !$past(frame_sync_8k_out, 2)) or ##1 $rose(frame_sync_8k_out))
    else $error("mode changed away from frame start");
  a_sync_width: assert property ($rose(frame_sync_8k_out) |->
    ##11 frame_sync_8k_out ##1 !frame_sync_8k_out)
    else $error("frame pulse width wrong");
  a_sync_period: assert property ($rose(frame_sync_8k_out) && seen |-> gap == FRAME_CYC - 1)
    else $error("frame pulse period wrong");
  a_quick_norm: assert property (quick_acquire_active |-> normal_ind)
    else $error("fast lock outside normal");
  a_quick_follow: assert property (normal_ind && $past(quick_acquire_enable, 3) &&
    $past(quick_acquire_enable, 2) && $past(quick_acquire_enable) |-> quick_acquire_active)
    else $error("fast lock pin ignored");
  a_corr_norm: assert property (phase_step_correct_active |-> normal_ind)
    else $error("correction on outside normal");
  a_corr_pin: assert property ($rose(normal_ind) && $past(holdover_ind) |->
    ##1 (phase_step_correct_active == phase_step_correct_enable))
    else $error("correction not from pin on return");
  a_corr_free: assert property ($rose(normal_ind) && $past(freerun_ind) |->
    ##1 !phase_step_correct_active)
    else $error("correction on after freerun");
  a_lock_bound: assert property (ncnt == LK |-> lock_ind)
    else $error("lock not reached in time");
  c_holdover: cover property ($rose(holdover_ind));
  c_corr_on: cover property ($rose(phase_step_correct_active));
  c_locked: cover property ($rose(lock_ind));
endmodule
bind dpmsc_top dpmsc_asserts #(
  .FRAME_CYC(FRAME_CYC), .LOCK_FRAMES(LOCK_FRAMES)) dpmsc_asserts_inst (
  .aclk, .aresetn, .frame_sync_8k_out, .normal_ind, .holdover_ind, .freerun_ind, .lock_ind,
  .quick_acquire_enable, .quick_acquire_active, .phase_step_correct_enable,
  .phase_step_correct_active);
`default_nettype wire

// ==== test/dpmsc_ref_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpmsc_ref_model #(
  parameter real HALF_NS = 62.5
) (
  input  wire logic en_a,
  input  wire logic en_b,
  output logic      reference_in_a,
  output logic      reference_in_b
);
  logic ph = 1'b0;
  // Free-running network references, phase unrelated to aclk
  always #(HALF_NS) ph = ~ph;
  // A lost reference parks low
  assign reference_in_a = ph & en_a;
  assign reference_in_b = ph & en_b;
endmodule
`default_nettype wire

// ==== test/tb_dpll_mode_state_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_dpll_mode_state_control;
  localparam int FC = 50;
  localparam logic [23:0] NOM = 24'h5a5a5a;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic [1:0]  r;
  } dpmsc_note_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        op_select_hi = 1'b1, op_select_lo = 1'b0, ref_select = 1'b0;
  logic        phase_step_correct_enable = 1'b1, quick_acquire_enable = 1'b0;
  logic        ref0_freq_code_hi = 1'b1, ref0_freq_code_lo = 1'b1;
  logic        ref1_freq_code_hi = 1'b0, ref1_freq_code_lo = 1'b1;
  logic        en_a = 1'b1, en_b = 1'b1, reference_in_a, reference_in_b;
  logic [23:0] dco_freq_word = 24'h0, dco_freq_target, w1;
  logic        frame_sync_8k_out, normal_ind, holdover_ind, freerun_ind, lock_ind;
  logic        quick_acquire_active, phase_step_correct_active;
  logic        ref_a_ppm_alarm, ref_b_ppm_alarm;
  logic [31:0] seed = 32'h9b831977;
  int          n_errors = 0;
  int          compares = 0;
  dpmsc_note_t rq[$];
  dpmsc_note_t nt;
  logic [1:0]  bq[$];

  dpmsc_top #(.FRAME_CYC(FC), .LOCK_FRAMES(8), .FAST_FRAMES(4), .MON_FRAMES(4),
    .LOSS_CYC(2 * FC), .NOMINAL_WORD(NOM)) dpmsc_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_select_hi, .op_select_lo, .ref_select,
    .phase_step_correct_enable, .quick_acquire_enable, .ref0_freq_code_hi,
    .ref0_freq_code_lo, .ref1_freq_code_hi, .ref1_freq_code_lo, .reference_in_a,
    .reference_in_b, .dco_freq_word, .frame_sync_8k_out, .normal_ind, .holdover_ind,
    .freerun_ind, .lock_ind, .quick_acquire_active, .phase_step_correct_active,
    .ref_a_ppm_alarm, .ref_b_ppm_alarm, .dco_freq_target);
  dpmsc_ref_model dpmsc_ref_model_inst (.en_a, .en_b, .reference_in_a, .reference_in_b);

  always #5 aclk = ~aclk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  function automatic logic [31:0] st(input logic c, input logic [4:0] s);
    return {25'h0, c, 1'b0, s};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] r);
    rq.push_back('{e, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge frame_sync_8k_out);
    repeat (3) @(posedge aclk);
  endtask

  // Answers taken off the queues in order
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      nt = rq.pop_front();
      check("rdata", s_axi_rdata & nt.m, nt.e);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, nt.r});
    end
    if (s_axi_bvalid && s_axi_bready) begin
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    end
  end

  initial begin
    repeat (80000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end

  initial begin
    seed = xs(seed);
    dco_freq_word <= seed[23:0];
    w1 = seed[23:0];
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'hc, 32'hf, 32'h7, dpmsc_pkg::RESP_OKAY);
    rd(4'h4, 32'h5f, st(0, dpmsc_pkg::ST_FREE), dpmsc_pkg::RESP_OKAY);
    $display("Test reset done");
    op_select_hi <= 1'b0;
    tick(1);
    rd(4'h4, 32'h5f, st(0, dpmsc_pkg::ST_NORM), dpmsc_pkg::RESP_OKAY);
    repeat (12 * FC) @(posedge aclk);
    rd(4'h4, 32'h1a0, 32'h1a0, dpmsc_pkg::RESP_OKAY);
    repeat (300 * FC) @(posedge aclk);
    seed = xs(seed);
    dco_freq_word <= seed[23:0];
    repeat (2) @(posedge aclk);
    check("target", {8'h0, dco_freq_target}, {8'h0, seed[23:0]});
    repeat (200 * FC) @(posedge aclk);
    seed = xs(seed);
    dco_freq_word <= seed[23:0];
    op_select_lo <= 1'b1;
    tick(1);
    rd(4'h4, 32'h5f, st(0, dpmsc_pkg::ST_HOLD), dpmsc_pkg::RESP_OKAY);
    rd(4'h8, 32'hffffff, {8'h0, w1}, dpmsc_pkg::RESP_OKAY);
    check("target", {8'h0, dco_freq_target}, {8'h0, w1});
    op_select_lo <= 1'b0;
    tick(1);
    rd(4'h4, 32'h5f, st(1, dpmsc_pkg::ST_NORM), dpmsc_pkg::RESP_OKAY);
    op_select_hi <= 1'b1;
    op_select_lo <= 1'b1;
    tick(3);
    rd(4'h4, 32'h5f, st(1, dpmsc_pkg::ST_NORM), dpmsc_pkg::RESP_OKAY);
    op_select_hi <= 1'b0;
    op_select_lo <= 1'b0;
    $display("Test modes done");
    en_a <= 1'b0;
    tick(3);
    rd(4'h4, 32'h45f, st(0, dpmsc_pkg::ST_AUTO) | 32'h400, dpmsc_pkg::RESP_OKAY);
    en_a <= 1'b1;
    tick(2);
    rd(4'h4, 32'h5f, st(1, dpmsc_pkg::ST_NORM), dpmsc_pkg::RESP_OKAY);
    ref_select <= 1'b1;
    tick(1);
    rd(4'h4, 32'h5f, st(0, dpmsc_pkg::ST_SHORT), dpmsc_pkg::RESP_OKAY);
    tick(1);
    rd(4'h4, 32'h25f, st(1, dpmsc_pkg::ST_NORM) | 32'h200, dpmsc_pkg::RESP_OKAY);
    en_b <= 1'b0;
    tick(3);
    rd(4'h4, 32'h45f, st(0, dpmsc_pkg::ST_AUTO) | 32'h400, dpmsc_pkg::RESP_OKAY);
    ref_select <= 1'b0;
    tick(1);
    rd(4'h4, 32'h5f, st(0, dpmsc_pkg::ST_SHORT), dpmsc_pkg::RESP_OKAY);
    en_b <= 1'b1;
    phase_step_correct_enable <= 1'b0;
    tick(1);
    rd(4'h4, 32'h25f, st(0, dpmsc_pkg::ST_NORM), dpmsc_pkg::RESP_OKAY);
    phase_step_correct_enable <= 1'b1;
    $display("Test automatic done");
    op_select_hi <= 1'b1;
    tick(1);
    rd(4'h4, 32'h5f, st(0, dpmsc_pkg::ST_FREE), dpmsc_pkg::RESP_OKAY);
    check("target", {8'h0, dco_freq_target}, {8'h0, NOM});
    quick_acquire_enable <= 1'b1;
    op_select_hi <= 1'b0;
    tick(1);
    check("quick", {31'h0, quick_acquire_active}, 32'h1);
    repeat (7 * FC) @(posedge aclk);
    rd(4'h4, 32'h20, 32'h20, dpmsc_pkg::RESP_OKAY);
    $display("Test freerun and fast lock done");
    seed = xs(seed);
    wr(4'h0, 32'h2, dpmsc_pkg::RESP_OKAY);
    rd(4'h0, 32'h3, 32'h2, dpmsc_pkg::RESP_OKAY);
    wr(4'h0, 32'h0, dpmsc_pkg::RESP_OKAY);
    wr(4'h4, seed, dpmsc_pkg::RESP_OKAY);
    rd(4'h6, 32'hffffffff, 32'h0, dpmsc_pkg::RESP_SLVERR);
    wr(4'h6, seed, dpmsc_pkg::RESP_SLVERR);
    $display("Test register bus done");
    ref0_freq_code_hi <= 1'b0;
    ref0_freq_code_lo <= 1'b0;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'hc, 32'hf, 32'h4, dpmsc_pkg::RESP_OKAY);
    rd(4'h4, 32'h5f, st(0, dpmsc_pkg::ST_NORM), dpmsc_pkg::RESP_OKAY);
    $display("Test second reset done");
    repeat (5) @(posedge aclk);
    wrap_up();
  end
endmodule
`default_nettype wire
